/* shared/omsd_defs.svh */
/*
  Constants of the operating mode strap decoder: register offsets, field positions, reset values.
  Assumes inclusion by bare name from the top module.
*/
`ifndef OMSD_DEFS_SVH
`define OMSD_DEFS_SVH

// register byte offsets
`define OMSD_STATUS_OFFS     12'h000
`define OMSD_CONTROL_OFFS    12'h004

// status fields
`define OMSD_ST_MODE_LSB     0
`define OMSD_ST_PINS_LSB     4
`define OMSD_ST_RSVD_BIT     8

// control fields
`define OMSD_CT_FREEZE_BIT   0

// reset values
`define OMSD_CONTROL_RST     1'h0
`define OMSD_PINS_RST        4'h0

// bus answers
`define OMSD_RESP_OKAY       2'h0
`define OMSD_RESP_DECERR     2'h3

`endif

/* shared/omsd_pkg.sv */
/*
  Types of the operating mode strap decoder.
  Assumes nothing beyond the defs header.
*/
package omsd_pkg;

  // one-hot operating modes
  typedef enum logic [3:0] {
    OMSD_NORMAL   = 4'h1,
    OMSD_ISO_PD   = 4'h2,
    OMSD_FULL_PD  = 4'h4,
    OMSD_XOR_TREE = 4'h8
  } omsd_mode_e;

  // pin order in the packed strap vector: [3] enable, [2] clock, [1] input, [0] execute
  typedef logic [3:0] omsd_pins_t;

endpackage : omsd_pkg

/* shared/omsd_strap_if.sv */
/*
  Carrier between the top module and the strap decoder.
  Assumes the top drives the registered strap levels and reads the decoded mode.
*/
`timescale 1ns/1ps
interface omsd_strap_if;
  import omsd_pkg::*;
  omsd_pins_t pins;
  omsd_mode_e mode;
  logic       reserved;

  modport dec (input pins, output mode, output reserved);
  modport top (output pins, input mode, input reserved);
endinterface : omsd_strap_if

/* rtl/omsd_decoder.sv */
/*
  Combinational decode of the four strap levels into the operating mode.
  Assumes registered, static strap levels arrive on the interface.
*/
`timescale 1ns/1ps
module omsd_decoder (
  // strap levels in, mode out
  omsd_strap_if.dec strap
);
  import omsd_pkg::*;

  always_comb begin
    strap.reserved = 1'b0;
    case (strap.pins)
      4'h0: strap.mode = OMSD_NORMAL;
      4'h7: strap.mode = OMSD_ISO_PD;
      4'hF: strap.mode = OMSD_FULL_PD;
      4'h8: strap.mode = OMSD_XOR_TREE;
      default: begin
        // a reserved code must not leave the part half isolated
        strap.mode     = OMSD_NORMAL;
        strap.reserved = 1'b1;
      end
    endcase
  end

endmodule : omsd_decoder

/* rtl/omsd_top.sv */
/*
  Operating mode strap decoder: samples the four configuration straps, decodes the global
  mode, drives the isolation and power-down controls, and offers status/control over AXI4-Lite.
  Assumes strap pins are synchronous to mclk, pad pull-downs on the three isolate straps,
  and a well-behaved AXI4-Lite master.
*/
// Behaviour
// - all four straps low selects normal functional operation.
// - floating isolate straps read low, so partial or open straps decode as normal while enable is low.
// - enable low, other three high: outputs high impedance and power-down.
// - all four straps high: outputs high impedance and complete power-down.
// - enable high, others low: XOR-tree board test with outputs high impedance.
`timescale 1ns/1ps
`include "omsd_defs.svh"
module omsd_top #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // configuration straps
  input  wire logic                test_mode_enable_pin,
  input  wire logic                isolate_test_clock_pin,
  input  wire logic                isolate_test_input_pin,
  input  wire logic                isolate_test_execute_pin,
  // decoded mode controls
  output      omsd_pkg::omsd_mode_e modeOut,
  output      logic                outputHighZ,
  output      logic                powerDown,
  output      logic                fullPowerDown,
  output      logic                xorTreeEnable,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  // axi4-lite write response
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  // axi4-lite read data
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import omsd_pkg::*;

  // register byte addresses at the bus width; decode looks at the word index only
  localparam logic [ADDR_W-1:0] StatusAddr  = ADDR_W'(`OMSD_STATUS_OFFS);
  localparam logic [ADDR_W-1:0] ControlAddr = ADDR_W'(`OMSD_CONTROL_OFFS);

  omsd_strap_if strap ();

  omsd_pins_t      pins_q,     pins_d;
  omsd_mode_e      mode_q,     mode_d;
  logic            highZ_q,    highZ_d;
  logic            pd_q,       pd_d;
  logic            fullPd_q,   fullPd_d;
  logic            xor_q,      xor_d;
  logic            freeze_q,   freeze_d;
  logic            rsvdSeen_q, rsvdSeen_d;
  logic            awHeld_q,   awHeld_d;
  logic [ADDR_W-1:0] awAddr_q, awAddr_d;
  logic            wHeld_q,    wHeld_d;
  logic [31:0]     wData_q,    wData_d;
  logic [3:0]      wStrb_q,    wStrb_d;
  logic            awReady_q,  awReady_d;
  logic            wReady_q,   wReady_d;
  logic            bValid_q,   bValid_d;
  logic [1:0]      bResp_q,    bResp_d;
  logic            arReady_q,  arReady_d;
  logic            rValid_q,   rValid_d;
  logic [31:0]     rData_q,    rData_d;
  logic [1:0]      rResp_q,    rResp_d;
  logic [31:0]     statusWord;
  logic            rsvdClear;

  assign strap.pins = pins_q;

  omsd_decoder u_decoder (
    .strap (strap)
  );

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`OMSD_ST_MODE_LSB +: 4] = mode_q;
    statusWord[`OMSD_ST_PINS_LSB +: 4] = pins_q;
    statusWord[`OMSD_ST_RSVD_BIT]      = rsvdSeen_q;
  end

  always_comb begin
    pins_d     = {test_mode_enable_pin, isolate_test_clock_pin,
                  isolate_test_input_pin, isolate_test_execute_pin};
    // freeze lets software pin the mode while straps are reworked on the bench
    mode_d     = freeze_q ? mode_q : strap.mode;
    highZ_d    = (mode_d != OMSD_NORMAL);
    pd_d       = (mode_d == OMSD_ISO_PD) || (mode_d == OMSD_FULL_PD);
    fullPd_d   = (mode_d == OMSD_FULL_PD);
    xor_d      = (mode_d == OMSD_XOR_TREE);
    freeze_d   = freeze_q;
    rsvdClear  = 1'b0;
    awHeld_d   = awHeld_q;
    awAddr_d   = awAddr_q;
    wHeld_d    = wHeld_q;
    wData_d    = wData_q;
    wStrb_d    = wStrb_q;
    bValid_d   = bValid_q;
    bResp_d    = bResp_q;
    rValid_d   = rValid_q;
    rData_d    = rData_q;
    rResp_d    = rResp_q;

    if (s_axi_awvalid && awReady_q) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_q) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (awHeld_q && wHeld_q && !bValid_q) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = `OMSD_RESP_OKAY;
      if (awAddr_q[ADDR_W-1:2] == StatusAddr[ADDR_W-1:2]) begin
        rsvdClear = wStrb_q[1] && wData_q[`OMSD_ST_RSVD_BIT];
      end else if (awAddr_q[ADDR_W-1:2] == ControlAddr[ADDR_W-1:2]) begin
        if (wStrb_q[0]) begin
          freeze_d = wData_q[`OMSD_CT_FREEZE_BIT];
        end
      end else begin
        bResp_d = `OMSD_RESP_DECERR;
      end
    end

    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
    if (s_axi_arvalid && arReady_q) begin
      rValid_d = 1'b1;
      rResp_d  = `OMSD_RESP_OKAY;
      if (s_axi_araddr[ADDR_W-1:2] == StatusAddr[ADDR_W-1:2]) begin
        rData_d = statusWord;
      end else if (s_axi_araddr[ADDR_W-1:2] == ControlAddr[ADDR_W-1:2]) begin
        rData_d = {31'h0000_0000, freeze_q};
      end else begin
        rData_d = 32'h0000_0000;
        rResp_d = `OMSD_RESP_DECERR;
      end
    end

    // a new reserved sighting beats a clear in the same cycle
    rsvdSeen_d = (rsvdSeen_q && !rsvdClear) || strap.reserved;
    awReady_d  = !awHeld_d && !bValid_d;
    wReady_d   = !wHeld_d && !bValid_d;
    arReady_d  = !rValid_d;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pins_q     <= `OMSD_PINS_RST;
      mode_q     <= OMSD_NORMAL;
      highZ_q    <= 1'b0;
      pd_q       <= 1'b0;
      fullPd_q   <= 1'b0;
      xor_q      <= 1'b0;
      freeze_q   <= `OMSD_CONTROL_RST;
      rsvdSeen_q <= 1'b0;
      awHeld_q   <= 1'b0;
      awAddr_q   <= '0;
      wHeld_q    <= 1'b0;
      wData_q    <= 32'h0000_0000;
      wStrb_q    <= 4'h0;
      awReady_q  <= 1'b0;
      wReady_q   <= 1'b0;
      bValid_q   <= 1'b0;
      bResp_q    <= `OMSD_RESP_OKAY;
      arReady_q  <= 1'b0;
      rValid_q   <= 1'b0;
      rData_q    <= 32'h0000_0000;
      rResp_q    <= `OMSD_RESP_OKAY;
    end else begin
      pins_q     <= pins_d;
      mode_q     <= mode_d;
      highZ_q    <= highZ_d;
      pd_q       <= pd_d;
      fullPd_q   <= fullPd_d;
      xor_q      <= xor_d;
      freeze_q   <= freeze_d;
      rsvdSeen_q <= rsvdSeen_d;
      awHeld_q   <= awHeld_d;
      awAddr_q   <= awAddr_d;
      wHeld_q    <= wHeld_d;
      wData_q    <= wData_d;
      wStrb_q    <= wStrb_d;
      awReady_q  <= awReady_d;
      wReady_q   <= wReady_d;
      bValid_q   <= bValid_d;
      bResp_q    <= bResp_d;
      arReady_q  <= arReady_d;
      rValid_q   <= rValid_d;
      rData_q    <= rData_d;
      rResp_q    <= rResp_d;
    end
  end

  assign modeOut       = mode_q;
  assign outputHighZ   = highZ_q;
  assign powerDown     = pd_q;
  assign fullPowerDown = fullPd_q;
  assign xorTreeEnable = xor_q;
  assign s_axi_awready = awReady_q;
  assign s_axi_wready  = wReady_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  a_normal_when_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (pins_q == 4'h0 && !freeze_q) |=> (mode_q == OMSD_NORMAL && !highZ_q && !pd_q && !xor_q))
    else $error("all-low straps did not give normal mode");

  a_open_straps_normal: assert property (@(posedge mclk) disable iff (!rst_n)
    (!pins_q[3] && pins_q[2:0] != 3'h7 && !freeze_q) |=> (mode_q == OMSD_NORMAL && !highZ_q))
    else $error("partly open isolate straps left normal mode");

  a_isolate_power_down: assert property (@(posedge mclk) disable iff (!rst_n)
    (pins_q == 4'h7 && !freeze_q) |=> (highZ_q && pd_q && !fullPd_q && mode_q == OMSD_ISO_PD))
    else $error("isolate code did not tri-state and power down");

  a_full_power_down: assert property (@(posedge mclk) disable iff (!rst_n)
    (pins_q == 4'hF && !freeze_q) |=> (highZ_q && pd_q && fullPd_q && !xor_q))
    else $error("all-high straps did not fully power down");

  a_xor_tree_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    (pins_q == 4'h8 && !freeze_q) |=> (xor_q && highZ_q && !pd_q && mode_q == OMSD_XOR_TREE))
    else $error("xor-tree code did not enter board test");

  a_reserved_normal: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap.reserved && !freeze_q) |=> (mode_q == OMSD_NORMAL && rsvdSeen_q))
    else $error("reserved straps not decoded as normal");

  a_strap_to_output: assert property (@(posedge mclk) disable iff (!rst_n)
    (!freeze_q && $stable(pins_d) && pins_d == 4'hF) |-> ##2 (fullPd_q || freeze_q))
    else $error("strap change not reflected two edges later");

  a_freeze_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    freeze_q |=> $stable(mode_q))
    else $error("frozen mode moved");

endmodule : omsd_top

/* sim/omsd_strap_model.sv */
/*
  Board strap model: turns a commanded four-bit code into the four strap levels.
  Assumes the bench steers code, floating and reserved permission on mclk edges.
*/
`timescale 1ns/1ps
module omsd_strap_model (
  // commands from the bench
  input  wire omsd_pkg::omsd_pins_t code,
  input  wire logic                 floatPins,
  input  wire logic                 allowRsvd,
  // strap pins
  output logic                      enPin,
  output logic                      clkPin,
  output logic                      inPin,
  output logic                      exPin
);
  import omsd_pkg::*;
  omsd_pins_t drv;
  // a reserved code reaches the pins only when a scenario asks for it
  assign drv = (allowRsvd || code inside {4'h0, 4'h7, 4'hF, 4'h8}) ? code : 4'h0;
  assign enPin = drv[3];
  // open isolate straps settle at the pad pull-down level
  assign clkPin = floatPins ? 1'b0 : drv[2];
  assign inPin = floatPins ? 1'b0 : drv[1];
  assign exPin = floatPins ? 1'b0 : drv[0];
endmodule : omsd_strap_model

/* sim/omsd_top_tb_top.sv */
/*
  Self-checking bench of the strap decoder: strap modes, reserved codes, freeze, bus.
  Assumes the strap model in the same folder and a 20 MHz mclk.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module omsd_top_tb_top;
  import omsd_pkg::*;
  logic mclk = 0, rst_n = 0, flt = 0, rsv = 0;
  omsd_pins_t code = 4'h0;
  logic en, ck, ti, ex, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr_, bv, arr, rv, hz, pd, fpd, xt;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [3:0] ws = 4'h0;
  logic [1:0] br, rr, r;
  omsd_mode_e mo;
  int n_fail = 0, num_checks = 0;
  always #25 mclk = ~mclk;
  omsd_strap_model i_model (.code(code), .floatPins(flt), .allowRsvd(rsv), .enPin(en), .clkPin(ck), .inPin(ti),
    .exPin(ex));
  omsd_top i_dut (.mclk(mclk), .rst_n(rst_n), .test_mode_enable_pin(en), .isolate_test_clock_pin(ck),
    .isolate_test_input_pin(ti), .isolate_test_execute_pin(ex), .modeOut(mo), .outputHighZ(hz), .powerDown(pd),
    .fullPowerDown(fpd), .xorTreeEnable(xt), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // write both channels together, drop each once taken, hold bready until bvalid
  // no cycle count is assumed: only the watchdog ends a wait for the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
    @(posedge mclk);
    awa <= a; awv <= 1'h1; wd <= v; ws <= s; wv <= 1'h1; bry <= 1'h1;
    forever begin
      @(posedge mclk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wr_) wv <= 1'h0;
      if (bv) begin rs = br; bry <= 1'h0; break; end
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    ara <= a; arv <= 1'h1; rry <= 1'h1;
    forever begin
      @(posedge mclk);
      if (arv && arr) arv <= 1'h0;
      if (rv) begin v = rdat; rs = rr; rry <= 1'h0; break; end
    end
  endtask : rd
  // outputs settle two edges after the straps move; one spare edge before looking
  task automatic set_pins(input omsd_pins_t c, input logic f, input logic rs);
    @(posedge mclk);
    code <= c; flt <= f; rsv <= rs;
    repeat (3) @(posedge mclk);
    #1;
  endtask : set_pins
  task automatic chk_out(input logic [3:0] m);
    `CHK("mode+ctl", {m, m != 4'h1, m == 4'h2 || m == 4'h4, m == 4'h4, m == 4'h8}, {mo, hz, pd, fpd, xt})
  endtask : chk_out
  task automatic t_reset;
    chk_out(4'h1);
    rd(12'h000, d, r);
    `CHK("status", 32'h00000001, d)
    rd(12'h004, d, r);
    `CHK("control", 32'h00000000, d)
  endtask : t_reset
  task automatic t_modes;
    omsd_pins_t c [4] = '{4'h0, 4'h7, 4'hF, 4'h8};
    logic [3:0] m [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    for (int i = 0; i < 4; i++) begin
      set_pins(c[i], 1'b0, 1'b0);
      chk_out(m[i]);
      rd(12'h000, d, r);
      `CHK("status", {23'h0, 1'b0, c[i], m[i]}, {d[31:2], r == 2'h0 ? d[1:0] : 2'h3})
    end
  endtask : t_modes
  task automatic t_float;
    set_pins(4'h7, 1'b1, 1'b0);
    chk_out(4'h1);
    set_pins(4'hF, 1'b1, 1'b0);
    chk_out(4'h8);
  endtask : t_float
  task automatic t_reserved;
    set_pins(4'h5, 1'b0, 1'b1);
    chk_out(4'h1);
    set_pins(4'hC, 1'b0, 1'b1);
    chk_out(4'h1);
    rd(12'h000, d, r);
    `CHK("status", 32'h000001C1, d)
    set_pins(4'h0, 1'b0, 1'b0);
    wr(12'h000, 32'h00000100, 4'h2, r);
    rd(12'h000, d, r);
    `CHK("status", 32'h00000001, d)
  endtask : t_reserved
  // freeze holds the decoded mode; unmapped places answer with a decode error
  task automatic t_freeze;
    set_pins(4'hF, 1'b0, 1'b0);
    wr(12'h004, 32'h00000001, 4'h1, r);
    set_pins(4'h0, 1'b0, 1'b0);
    chk_out(4'h4);
    wr(12'h004, 32'h00000000, 4'h1, r);
    set_pins(4'h0, 1'b0, 1'b0);
    chk_out(4'h1);
    wr(12'h008, 32'hFFFFFFFF, 4'hF, r);
    `CHK("bresp", 2'h3, r)
    rd(12'h008, d, r);
    `CHK("rdata+rresp", {32'h0, 2'h3}, {d, r})
  endtask : t_freeze
  // a reset in mid-run drops freeze; the straps rule again two edges after release
  task automatic t_rerun;
    set_pins(4'h7, 1'b0, 1'b0);
    wr(12'h004, 32'h00000001, 4'h1, r);
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    chk_out(4'h1);
    @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    #1;
    chk_out(4'h2);
    rd(12'h004, d, r);
    `CHK("control", 32'h00000000, d)
  endtask : t_rerun
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    repeat (2) @(posedge mclk);
    #1;
    t_reset();
    t_modes();
    t_float();
    t_reserved();
    t_freeze();
    t_rerun();
    close_out();
  end
endmodule : omsd_top_tb_top
